//--- rtl/hpb_host_port.sv
//
// Overview of operation
// - bus-mux strap high selects multiplexed bus
// - latch bus-mux strap at reset release
// - endian strap high little, low big
// - width strap high 32 bits, low 16
// - latch endian and width straps at release
// - reset clears registers except the idle-high strobe copies, straps open for sampling
// - address sampled on chip select falling edge
// - chip select rising edge ends the cycle
// - addresses are 32-bit word aligned
// - line 5 carries bit 5, ignored when multiplexed
// - timer lines 4 to 7 are outputs only
// - timer line 3 is output or input
// - multiplexed mode: line 2 is address latch
// - write strobe low writes, high reads
// - drive data only while output enable low
//
`timescale 1ns/10ps
`default_nettype none

`include "hpb_regs.svh"

module hpb_host_port #(
	parameter int WADDR_W = 8	// word address width, more than 4
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               arst_n_i,
	// configuration straps
	input  wire logic               bus_mux_select_i,
	input  wire logic               endian_select_i,
	input  wire logic               size_32_i,
	// host bus strobes
	input  wire logic               cs_n_i,
	input  wire logic               we_n_i,
	input  wire logic               oe_n_i,
	// host address lines
	input  wire logic               addr_line_2_i,
	input  wire logic               addr_line_3_i,
	input  wire logic               addr_line_4_i,
	input  wire logic               addr_line_5_i,
	// host data lines, split for the pad
	input  wire logic [31:0]        data_i,
	output logic      [31:0]        data_o,
	output logic      [31:0]        data_oe_o,
	// internal access port
	output logic                    acc_req_o,
	output logic                    acc_we_o,
	output logic      [WADDR_W-1:0] acc_addr_o,
	output logic      [31:0]        acc_wdata_o,
	input  wire logic [31:0]        acc_rdata_i,
	// latched configuration
	output logic                    cfg_ready_o,
	output logic                    cfg_mux_o,
	output logic                    cfg_little_o,
	output logic                    cfg_wide_o,
	// precision timer lines
	input  wire logic [3:0]         tmr_level_i,
	input  wire logic [3:0]         tmr_en_i,
	input  wire logic               tmr3_level_i,
	input  wire logic               tmr3_dir_out_i,
	output logic                    precision_pulse_out_4_o,
	output logic                    precision_pulse_out_5_o,
	output logic                    precision_pulse_out_6_o,
	output logic                    precision_pulse_out_7_o,
	input  wire logic               precision_pulse_io_3_i,
	output logic                    precision_pulse_io_3_o,
	output logic                    precision_pulse_io_3_oe_o,
	output logic                    tmr3_in_o
);

	// ------------------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------------------
	hpb_pin_if #(.W(`HPB_PIN_W)) pin_bus ();

	assign pin_bus.raw = {precision_pulse_io_3_i, size_32_i, endian_select_i,
		bus_mux_select_i, addr_line_5_i, addr_line_4_i, addr_line_3_i,
		addr_line_2_i, oe_n_i, we_n_i, cs_n_i, data_i};

	hpb_pin_sync #(
		.W   (`HPB_PIN_W),
		.RST (`HPB_PIN_RST)
	) u_sync (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.pins     (pin_bus.sync)
	);

	// filtered pin levels
	logic        cs_n;		// chip select
	logic        we_n;		// write strobe
	logic        oe_n;		// output drive enable
	logic        ale;		// line 2 doubles as address latch
	logic [3:0]  line_addr;	// dedicated lines 5..2
	logic [31:0] bus_data;	// data lines

	assign cs_n      = pin_bus.clean[`HPB_PIN_CS];
	assign we_n      = pin_bus.clean[`HPB_PIN_WE];
	assign oe_n      = pin_bus.clean[`HPB_PIN_OE];
	assign ale       = pin_bus.clean[`HPB_PIN_A2];
	assign line_addr = pin_bus.clean[`HPB_PIN_A5:`HPB_PIN_A2];
	assign bus_data  = pin_bus.clean[`HPB_PIN_DATA_HI:`HPB_PIN_DATA_LO];

	// ------------------------------------------------------------------------
	// lane ordering
	// ------------------------------------------------------------------------
	// internal words are little endian; big endian swaps bytes within the
	// active width. the swap is its own inverse, so reads and writes share it
	function automatic logic [31:0] lane_map(input logic [31:0] d,
		input logic little, input logic wide);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (little && wide) begin
			r = d;
		end else if (little) begin
			r = {16'h0000, d[15:0]};
		end else if (wide) begin
			r = {d[7:0], d[15:8], d[23:16], d[31:24]};
		end else begin
			r = {16'h0000, d[7:0], d[15:8]};
		end
		return r;
	endfunction

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	hpb_pkg::hpb_state_t state_r, state_nxt;	// control state
	logic [2:0]          settle_r, settle_nxt;	// strap settling count
	logic                mux_r, mux_nxt;		// multiplexed bus
	logic                little_r, little_nxt;	// little endian
	logic                wide_r, wide_nxt;	// 32-bit data bus
	logic                cs_q_r, cs_q_nxt;	// chip select, last cycle
	logic                ale_q_r, ale_q_nxt;	// address latch, last cycle
	logic [WADDR_W-1:0]  mux_addr_r, mux_addr_nxt;	// address from address phase
	logic [WADDR_W-1:0]  addr_r, addr_nxt;	// address of open cycle
	logic                wr_r, wr_nxt;		// open cycle is a write
	logic                req_r, req_nxt;		// access request pulse
	logic                rvalid_r, rvalid_nxt;	// read data held
	logic [31:0]         wdata_r, wdata_nxt;	// write data
	logic [31:0]         rdata_r, rdata_nxt;	// read data to the pins

	logic cs_fall;	// chip select edges
	logic cs_rise;
	logic ale_fall;	// end of address phase

	assign cs_fall  = cs_q_r & ~cs_n;
	assign cs_rise  = ~cs_q_r & cs_n;
	assign ale_fall = ale_q_r & ~ale;

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		state_nxt    = state_r;
		settle_nxt   = settle_r;
		mux_nxt      = mux_r;
		little_nxt   = little_r;
		wide_nxt     = wide_r;
		cs_q_nxt     = cs_n;
		ale_q_nxt    = ale;
		mux_addr_nxt = mux_addr_r;
		addr_nxt     = addr_r;
		wr_nxt       = wr_r;
		req_nxt      = 1'b0;
		rvalid_nxt   = rvalid_r;
		wdata_nxt    = wdata_r;
		rdata_nxt    = rdata_r;

		// address phase of the multiplexed bus, latched as the strobe drops
		if (mux_r && ale_fall) begin
			mux_addr_nxt = bus_data[`HPB_WORD_SHIFT +: WADDR_W];
		end

		case (state_r)
			// straps were open during reset; the level that stands once the
			// synchroniser has filled is the one at release
			hpb_pkg::HPB_ST_STRAP: begin
				if (settle_r == `HPB_STRAP_SETTLE) begin
					mux_nxt    = pin_bus.clean[`HPB_PIN_MUX];
					little_nxt = pin_bus.clean[`HPB_PIN_ENDIAN];
					wide_nxt   = pin_bus.clean[`HPB_PIN_SIZE];
					state_nxt  = hpb_pkg::HPB_ST_IDLE;
				end else begin
					settle_nxt = settle_r + 3'h1;
				end
			end
			// a cycle opens on the falling chip select
			hpb_pkg::HPB_ST_IDLE: begin
				if (cs_fall) begin
					if (mux_r) begin
						addr_nxt = mux_addr_r;
					end else begin
						addr_nxt = {{(WADDR_W-4){1'b0}}, line_addr};
					end
					wr_nxt     = ~we_n;
					rvalid_nxt = 1'b0;
					req_nxt    = we_n;	// reads start at once
					state_nxt  = hpb_pkg::HPB_ST_BUSY;
				end
			end
			// reads answer while open; writes commit as the cycle closes,
			// since the host data only has to be stable by then
			hpb_pkg::HPB_ST_BUSY: begin
				if (req_r && !wr_r) begin
					rdata_nxt  = lane_map(acc_rdata_i, little_r, wide_r);
					rvalid_nxt = 1'b1;
				end
				if (cs_rise) begin
					if (wr_r) begin
						wdata_nxt = lane_map(bus_data, little_r, wide_r);
						req_nxt   = 1'b1;
					end
					rvalid_nxt = 1'b0;
					state_nxt  = hpb_pkg::HPB_ST_IDLE;
				end
			end
			default: begin
				state_nxt = hpb_pkg::HPB_ST_STRAP;
			end
		endcase
	end

	// registers only
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r    <= hpb_pkg::HPB_ST_STRAP;
			settle_r   <= 3'h0;
			mux_r      <= 1'b0;
			little_r   <= 1'b0;
			wide_r     <= 1'b0;
			cs_q_r     <= 1'b1;
			ale_q_r    <= 1'b0;
			mux_addr_r <= '0;
			addr_r     <= '0;
			wr_r       <= 1'b0;
			req_r      <= 1'b0;
			rvalid_r   <= 1'b0;
			wdata_r    <= 32'h0000_0000;
			rdata_r    <= 32'h0000_0000;
		end else begin
			state_r    <= state_nxt;
			settle_r   <= settle_nxt;
			mux_r      <= mux_nxt;
			little_r   <= little_nxt;
			wide_r     <= wide_nxt;
			cs_q_r     <= cs_q_nxt;
			ale_q_r    <= ale_q_nxt;
			mux_addr_r <= mux_addr_nxt;
			addr_r     <= addr_nxt;
			wr_r       <= wr_nxt;
			req_r      <= req_nxt;
			rvalid_r   <= rvalid_nxt;
			wdata_r    <= wdata_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// data pad drive
	// ------------------------------------------------------------------------
	// drive only inside a read cycle with data ready and output enable low;
	// the enable path is combinational, so the pad releases one filtered
	// sample after the host lets go
	logic drive;
	assign drive = (state_r == hpb_pkg::HPB_ST_BUSY) && !wr_r && rvalid_r && !oe_n;

	// upper sixteen lanes stay released in 16-bit mode
	assign data_oe_o = {{`HPB_HALF_W{drive & wide_r}}, {`HPB_HALF_W{drive}}};
	assign data_o    = rdata_r;

	// internal access port
	assign acc_req_o   = req_r;
	assign acc_we_o    = wr_r;
	assign acc_addr_o  = addr_r;
	assign acc_wdata_o = wdata_r;

	// latched configuration
	assign cfg_ready_o  = (state_r != hpb_pkg::HPB_ST_STRAP);
	assign cfg_mux_o    = mux_r;
	assign cfg_little_o = little_r;
	assign cfg_wide_o   = wide_r;

	// ------------------------------------------------------------------------
	// precision timer lines
	// ------------------------------------------------------------------------
	// timer levels come from the internal timer on this clock; no sync
	logic [3:0] tmr_r, tmr_nxt;	// output-only lines 4..7
	logic       t3_r, t3_nxt;	// line 3 output level

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_tmr
			always_comb begin
				tmr_nxt[gi] = tmr_level_i[gi] & tmr_en_i[gi];
			end
		end
	endgenerate

	always_comb begin
		t3_nxt = tmr3_level_i;
	end

	// registers only
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tmr_r <= 4'h0;
			t3_r  <= 1'b0;
		end else begin
			tmr_r <= tmr_nxt;
			t3_r  <= t3_nxt;
		end
	end

	assign precision_pulse_out_4_o   = tmr_r[0];
	assign precision_pulse_out_5_o   = tmr_r[1];
	assign precision_pulse_out_6_o   = tmr_r[2];
	assign precision_pulse_out_7_o   = tmr_r[3];
	assign precision_pulse_io_3_o    = t3_r;
	assign precision_pulse_io_3_oe_o = tmr3_dir_out_i;
	// input direction: filtered pin level, masked while driving
	assign tmr3_in_o = pin_bus.clean[`HPB_PIN_T3] & ~tmr3_dir_out_i;

endmodule

`default_nettype wire

//--- rtl/hpb_pin_if.sv
`timescale 1ns/10ps
`default_nettype none

// raw pin levels in, filtered levels out
interface hpb_pin_if #(
	parameter int W = 8
);
	logic [W-1:0] raw;	// pin levels, asynchronous
	logic [W-1:0] clean;	// filtered levels, clk_i domain

	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

`default_nettype wire

//--- rtl/hpb_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

`include "hpb_regs.svh"

// three-stage synchroniser; a bit changes once stages two and three agree
module hpb_pin_sync #(
	parameter int           W   = 8,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	// pin vector
	hpb_pin_if.sync   pins
);

	logic [W-1:0] st1_r;	// first stage, read only by st2_r
	logic [W-1:0] st2_r;	// second stage
	logic [W-1:0] st3_r;	// third stage
	logic [W-1:0] clean_r;	// filtered level
	logic [W-1:0] clean_nxt;

	// ------------------------------------------------------------------------
	// filter: take stage three only where it agrees with stage two
	// ------------------------------------------------------------------------
	always_comb begin
		clean_nxt = (st3_r & ~(st2_r ^ st3_r)) | (clean_r & (st2_r ^ st3_r));
	end

	// registers only
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st1_r   <= RST;
			st2_r   <= RST;
			st3_r   <= RST;
			clean_r <= RST;
		end else begin
			st1_r   <= pins.raw;
			st2_r   <= st1_r;
			st3_r   <= st2_r;
			clean_r <= clean_nxt;
		end
	end

	assign pins.clean = clean_r;

endmodule

`default_nettype wire

//--- rtl/hpb_pkg.sv
package hpb_pkg;

	// ------------------------------------------------------------------------
	// control states of the host port
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		HPB_ST_STRAP = 2'b00,	// straps being sampled, no access taken
		HPB_ST_IDLE  = 2'b01,	// waiting for chip select to fall
		HPB_ST_BUSY  = 2'b10	// cycle open until chip select rises
	} hpb_state_t;

endpackage

//--- rtl/hpb_regs.svh
`ifndef HPB_REGS_SVH
`define HPB_REGS_SVH

// ----------------------------------------------------------------------------
// layout of the synchronised pin vector
// ----------------------------------------------------------------------------
`define HPB_PIN_DATA_LO  0
`define HPB_PIN_DATA_HI  31
`define HPB_PIN_CS       32
`define HPB_PIN_WE       33
`define HPB_PIN_OE       34
`define HPB_PIN_A2       35
`define HPB_PIN_A3       36
`define HPB_PIN_A4       37
`define HPB_PIN_A5       38
`define HPB_PIN_MUX      39
`define HPB_PIN_ENDIAN   40
`define HPB_PIN_SIZE     41
`define HPB_PIN_T3       42
`define HPB_PIN_W        43

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
// strobes (chip select, write, output enable) idle high
`define HPB_PIN_RST      43'h007_0000_0000
// cycles for a strap level to cross the three-stage synchroniser and its
// agreement filter; one fewer would latch the reset value of the filter
`define HPB_STRAP_SETTLE 3'h4
// lowest decoded address line carries byte address bit 2
`define HPB_WORD_SHIFT   2
// width of one half of the data bus
`define HPB_HALF_W       16

`endif

//--- sim/hpb_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// host processor: strobes, address and its side of the data lines
module hpb_host_model (
	// clock
	input  wire logic        clk_i,
	// strobes and address lines 5..2
	output logic             cs_n_o,
	output logic             we_n_o,
	output logic             oe_n_o,
	output logic [5:2]       addr_o,
	// data lines
	output logic [31:0]      data_o,
	input  wire logic [31:0] bus_i,
	input  wire logic [31:0] drv_i
);
	logic [31:0] last;	// last value driven; released lines show its inverse

	initial begin
		{cs_n_o, we_n_o, oe_n_o} = 3'h7;
		addr_o = 4'h0;
		last = 32'h0;
		data_o = 32'h0;
	end

	task automatic idle(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// drive, and record the value so that a release shows its inverse and no stale copy can pass for data
	task automatic put(input logic [31:0] v);
		data_o = v;
		last = v;
	endtask

	// address ahead of select; when multiplexed the latch strobe falls to take it
	task automatic addr_phase(input logic mux, input logic [7:0] wa, input logic [3:0] junk);
		if (mux) begin
			addr_o = {junk[2:0], 1'b1};
			put({22'h0, wa, 2'b00});
			idle(6);
			addr_o[2] = 1'b0;
			idle(3);
			data_o = ~last;
			idle(3);
		end else begin
			addr_o = wa[3:0];
			data_o = ~last;
			idle(2);
		end
	endtask

	task automatic write(input logic mux, input logic [7:0] wa, input logic [31:0] d, input logic [3:0] junk);
		addr_phase(mux, wa, junk);
		we_n_o = 1'b0;
		put(d);
		idle(2);
		cs_n_o = 1'b0;
		idle(10);
		cs_n_o = 1'b1;
		idle(8);
		we_n_o = 1'b1;
		data_o = ~last;
		idle(2);
	endtask

	task automatic read(input logic mux, input logic [7:0] wa, input logic [3:0] junk,
			output logic [31:0] q, output logic [31:0] en0, output logic [31:0] en1);
		addr_phase(mux, wa, junk);
		we_n_o = 1'b1;
		cs_n_o = 1'b0;
		idle(10);
		en0 = drv_i;
		oe_n_o = 1'b0;
		idle(8);
		q = bus_i;
		en1 = drv_i;
		oe_n_o = 1'b1;
		cs_n_o = 1'b1;
		idle(8);
	endtask

	// select pulled too early: must open no cycle
	task automatic hold_cs(input int n);
		cs_n_o = 1'b0;
		idle(n);
		cs_n_o = 1'b1;
		idle(8);
	endtask
endmodule

`default_nettype wire

//--- sim/hpb_host_properties.sv
`timescale 1ns/10ps
`default_nettype none

// watches the host port from its pins only; nothing inside is visible here
module hpb_props (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	// strobes and straps
	input  wire logic        cs_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        bus_mux_select_i,
	input  wire logic        endian_select_i,
	input  wire logic        size_32_i,
	// data drive and access port
	input  wire logic [31:0] data_oe_o,
	input  wire logic        acc_req_o,
	input  wire logic        acc_we_o,
	// latched configuration
	input  wire logic        cfg_ready_o,
	input  wire logic        cfg_mux_o,
	input  wire logic        cfg_little_o,
	input  wire logic        cfg_wide_o,
	// timer lines
	input  wire logic [3:0]  tmr_level_i,
	input  wire logic [3:0]  tmr_en_i,
	input  wire logic        tmr3_level_i,
	input  wire logic        tmr3_dir_out_i,
	input  wire logic        precision_pulse_out_4_o,
	input  wire logic        precision_pulse_out_5_o,
	input  wire logic        precision_pulse_out_6_o,
	input  wire logic        precision_pulse_out_7_o,
	input  wire logic        precision_pulse_io_3_o,
	input  wire logic        precision_pulse_io_3_oe_o,
	input  wire logic        tmr3_in_o
);
	// ------------------------------------------------------------------------
	// one clock domain, so one clocking and one disable
	// ------------------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	property p_no_early; !cfg_ready_o |-> !acc_req_o && data_oe_o == 32'h0; endproperty
	a_no_early: assert property (p_no_early) else $error("access before straps latched");
	property p_ready_time; $rose(arst_n_i) |-> !cfg_ready_o [*3] ##[1:4] cfg_ready_o; endproperty
	a_ready_time: assert property (p_ready_time) else $error("ready late or early");
	property p_taken;
		$rose(cfg_ready_o) |-> cfg_mux_o == $past(bus_mux_select_i, 5) && cfg_little_o == $past(endian_select_i, 5)
			&& cfg_wide_o == $past(size_32_i, 5);
	endproperty
	a_taken: assert property (p_taken) else $error("straps latched wrong");
	property p_held; cfg_ready_o |=> cfg_ready_o && $stable({cfg_mux_o, cfg_little_o, cfg_wide_o}); endproperty
	a_held: assert property (p_held) else $error("latched straps moved");
	property p_narrow; !cfg_wide_o |-> data_oe_o[31:16] == 16'h0; endproperty
	a_narrow: assert property (p_narrow) else $error("upper lanes driven");
	property p_oe_gate; oe_n_i [*6] |-> data_oe_o == 32'h0; endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("drive without enable");
	property p_wr_rise; acc_req_o && acc_we_o |-> cs_n_i && $past(cs_n_i, 2); endproperty
	a_wr_rise: assert property (p_wr_rise) else $error("write before select rose");
	property p_rd_fall; acc_req_o && !acc_we_o |-> !cs_n_i && !$past(cs_n_i, 2); endproperty
	a_rd_fall: assert property (p_rd_fall) else $error("read outside select");
	property p_pulse; acc_req_o |=> !acc_req_o; endproperty
	a_pulse: assert property (p_pulse) else $error("request longer than a cycle");
	property p_tmr;
		$past(arst_n_i) |-> {precision_pulse_out_7_o, precision_pulse_out_6_o, precision_pulse_out_5_o,
			precision_pulse_out_4_o} == ($past(tmr_level_i) & $past(tmr_en_i));
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer output wrong");
	property p_io3; $past(arst_n_i) |-> precision_pulse_io_3_oe_o == tmr3_dir_out_i
		&& precision_pulse_io_3_o == $past(tmr3_level_i); endproperty
	a_io3: assert property (p_io3) else $error("line 3 output wrong");
	property p_io3_in; tmr3_dir_out_i [*2] |-> !tmr3_in_o; endproperty
	a_io3_in: assert property (p_io3_in) else $error("line 3 input seen while output");
endmodule

bind hpb_host_port hpb_props u_props (.*);

`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	// ------------------------------------------------------------------------
	// pins, named as the ports so the device connects by name
	// ------------------------------------------------------------------------
	logic        clk_i, arst_n_i, bus_mux_select_i, endian_select_i, size_32_i;
	logic        cs_n_i, we_n_i, oe_n_i, addr_line_2_i, addr_line_3_i, addr_line_4_i, addr_line_5_i;
	logic [31:0] data_i, data_o, data_oe_o, acc_wdata_o, acc_rdata_i, hdata, d, q, en0, en1, mask;
	logic        acc_req_o, acc_we_o, cfg_ready_o, cfg_mux_o, cfg_little_o, cfg_wide_o, run_prev;
	logic [7:0]  acc_addr_o, wa;
	logic [5:2]  haddr;
	logic [3:0]  tmr_level_i, tmr_en_i;
	logic        tmr3_level_i, tmr3_dir_out_i, precision_pulse_io_3_i, precision_pulse_io_3_o, pin3_far;
	logic        precision_pulse_io_3_oe_o, tmr3_in_o, precision_pulse_out_4_o, precision_pulse_out_5_o;
	logic        precision_pulse_out_6_o, precision_pulse_out_7_o;
	logic [40:0] exp_q[$], e;	// expected requests: {write, word address, write data}
	int          seed, n_fail, comparisons, cycles;

	// wire levels from the device's enables; the host or far end drives the rest
	assign data_i = (data_o & data_oe_o) | (hdata & ~data_oe_o);
	assign precision_pulse_io_3_i = precision_pulse_io_3_oe_o ? precision_pulse_io_3_o : pin3_far;
	assign {addr_line_5_i, addr_line_4_i, addr_line_3_i, addr_line_2_i} = haddr;

	hpb_host_port u_dut (.*);
	hpb_host_model u_host (.clk_i(clk_i), .cs_n_o(cs_n_i), .we_n_o(we_n_i), .oe_n_o(oe_n_i), .addr_o(haddr),
		.data_o(hdata), .bus_i(data_i), .drv_i(data_oe_o));

	always #4 clk_i = ~clk_i;

	// behavioural lane order: big endian swaps bytes inside the active width
	function automatic logic [31:0] lanes(input logic [31:0] v, input logic little, input logic wide);
		logic [31:0] s;
		s = wide ? v : {16'h0, v[15:0]};
		if (!little) s = wide ? {s[7:0], s[15:8], s[23:16], s[31:24]} : {16'h0, s[7:0], s[15:8]};
		return s;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------------
	// timer stimulus and request monitor, both off the sampling edge
	// ------------------------------------------------------------------------
	always @(negedge clk_i) begin
		cycles++;
		if (cycles == 8000) begin
			n_fail++;
			summarize();
		end
		if (arst_n_i === 1'b1 && run_prev === 1'b1) begin
			check("timer_out", {28'h0, precision_pulse_out_7_o, precision_pulse_out_6_o, precision_pulse_out_5_o,
				precision_pulse_out_4_o}, {28'h0, tmr_level_i & tmr_en_i});
		end
		run_prev = arst_n_i;
		{tmr_level_i, tmr_en_i, tmr3_level_i} = 9'($random(seed));
		if (acc_req_o === 1'b1) begin
			e = (exp_q.size() == 0) ? 41'h1_ff00000000 : exp_q.pop_front();
			check("acc_we", {31'h0, acc_we_o}, {31'h0, e[40]});
			check("acc_addr", {24'h0, acc_addr_o}, {24'h0, e[39:32]});
			if (e[40]) check("acc_wdata", acc_wdata_o, e[31:0]);
		end
	end

	initial begin
		{seed, n_fail, comparisons, cycles} = {32'd77, 96'h0};
		{clk_i, arst_n_i, run_prev, bus_mux_select_i, endian_select_i, size_32_i} = 6'h0;
		{acc_rdata_i, tmr3_dir_out_i, pin3_far} = 34'h0;
		for (int k = 0; k < 8; k++) begin
			{bus_mux_select_i, endian_select_i, size_32_i} = 3'(k);
			arst_n_i = 1'b0;
			repeat (6) @(negedge clk_i);
			check("oe_reset", data_oe_o, 32'h0);
			check("ready_reset", {31'h0, cfg_ready_o}, 32'h0);
			arst_n_i = 1'b1;
			if (k == 3) u_host.hold_cs(12);
			for (int n = 0; n < 20 && cfg_ready_o !== 1'b1; n++) @(negedge clk_i);
			check("cfg", {29'h0, cfg_mux_o, cfg_little_o, cfg_wide_o}, 32'(k));
			{bus_mux_select_i, endian_select_i, size_32_i} = ~3'(k);
			mask = k[0] ? 32'hffffffff : 32'h0000ffff;
			repeat (2) begin
				wa = 8'($random(seed)) & (k[2] ? 8'hff : 8'h0f);
				d = $random(seed);
				exp_q.push_back({1'b1, wa, lanes(d, k[1], k[0])});
				u_host.write(k[2], wa, d, 4'($random(seed)));
				wa = 8'($random(seed)) & (k[2] ? 8'hff : 8'h0f);
				acc_rdata_i = $random(seed);
				exp_q.push_back({1'b0, wa, 32'h0});
				u_host.read(k[2], wa, 4'($random(seed)), q, en0, en1);
				check("oe_idle", en0, 32'h0);
				check("oe_on", en1, mask);
				check("read_data", q & mask, lanes(acc_rdata_i, k[1], k[0]));
			end
			check("pending", 32'(exp_q.size()), 32'h0);
		end
		for (int b = 0; b < 2; b++) begin
			pin3_far = b[0];
			repeat (8) @(negedge clk_i);
			check("pin3_in", {31'h0, tmr3_in_o}, 32'(b));
		end
		tmr3_dir_out_i = 1'b1;
		repeat (8) @(negedge clk_i);
		check("pin3_out", {31'h0, tmr3_in_o}, 32'h0);
		summarize();
	end
endmodule

`default_nettype wire
